// ===== pkg/npsp_defs.vh
`ifndef NPSP_DEFS_VH
`define NPSP_DEFS_VH
// ==========================================
// Clock and timing figures
`define NPSP_CLK_PERIOD_NS 4
`define NPSP_T_CYCLE_NS 150
`define NPSP_T_ACTIVE_NS 120
`define NPSP_T_PRECHARGE_NS 20
`define NPSP_T_HOLD_NS 50
`define NPSP_T_BYTE_SETUP_NS 5
`define NPSP_T_POWER_NS 85
`define NPSP_T_ACCESS_NS 100
// Cycle counts, least times round up
`define NPSP_CYC(ns) (((ns) + `NPSP_CLK_PERIOD_NS - 1) / `NPSP_CLK_PERIOD_NS)
`define NPSP_CYC_ACTIVE `NPSP_CYC(`NPSP_T_ACTIVE_NS)
`define NPSP_CYC_CYCLE `NPSP_CYC(`NPSP_T_CYCLE_NS)
`define NPSP_CYC_PRECHARGE `NPSP_CYC(`NPSP_T_PRECHARGE_NS)
`define NPSP_CYC_HOLD `NPSP_CYC(`NPSP_T_HOLD_NS)
`define NPSP_CYC_BYTE_SETUP `NPSP_CYC(`NPSP_T_BYTE_SETUP_NS)
`define NPSP_CYC_POWER `NPSP_CYC(`NPSP_T_POWER_NS)
`define NPSP_CYC_ACCESS `NPSP_CYC(`NPSP_T_ACCESS_NS)
// ==========================================
// Widths
`define NPSP_ADDR_W 16
`define NPSP_DATA_W 16
`endif

// ===== logic/npsp_timer.v
`timescale 1ns/10ps
`include "npsp_defs.vh"
// ==========================================
// Down counter, reports done when it has run out
module npsp_timer #(
  parameter W = 8
) (
  // Clock and reset
  input wire clk_sys,
  input wire reset,
  // Control
  input wire load,
  input wire [W-1:0] value,
  // Status
  output wire done
);
  reg [W-1:0] cnt_q;
  // Load or count down to zero
  always @(posedge clk_sys) begin
    if (reset) begin
      cnt_q <= {W{1'b0}};
    end else if (load) begin
      cnt_q <= value;
    end else if (cnt_q != {W{1'b0}}) begin
      cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
    end
  end
  // Done looks only at the count; load is decoded from done, so done must not look back at load
  assign done = (cnt_q == {W{1'b0}});
endmodule // npsp_timer

// ===== logic/npsp_host.v
`timescale 1ns/10ps
`include "npsp_defs.vh"
// Notes on behaviour
// RULE_01 - Memory holds 65536 words of 16 bits, word address and data both 16 bits.
// RULE_02 - Device floats both lanes whenever any standby condition holds.
// RULE_03 - Lower byte strobe gates low byte, upper strobe gates high byte.
// RULE_04 - Chip-select cycles latch address and data at low-active select falling edge.
// RULE_05 - Chip-select cycles latch address and data at high-active select rising edge.
// RULE_06 - Read: address valid when output strobe falls, selects active, write strobe high.
// RULE_07 - Write: address and data valid when write strobe falls, output strobe high.
// RULE_08 - Reads start at least 150 ns apart, strobes active at least 120 ns.
// RULE_09 - Controlling strobe goes inactive at least 20 ns between accesses.
// RULE_10 - Write strobe low at least 120 ns, write cycle at least 150 ns.
// RULE_11 - Write data held at least 50 ns after latching edge, setup may be zero.
// RULE_12 - Byte strobes asserted 5 ns before latching edge, active at least 120 ns.
// RULE_13 - Low-active select held inactive at least 85 ns before power removal.
// RULE_14 - Low-active select held inactive at least 85 ns after power before access.
// RULE_15 - Device keeps its drivers off during writes so host drives the bus.
module npsp_host #(
  parameter AW = `NPSP_ADDR_W,
  parameter DW = `NPSP_DATA_W
) (
  // Clock and reset
  input wire clk_sys,
  input wire reset,
  // User request side
  input wire req_valid,
  input wire req_write,
  input wire [AW-1:0] req_addr,
  input wire [DW-1:0] req_wdata,
  input wire [1:0] req_byte_en,
  output reg req_ready,
  output reg [DW-1:0] rsp_rdata,
  output reg rsp_valid,
  // Power control
  input wire power_down_req,
  output reg power_safe,
  // Memory pins
  output reg [AW-1:0] word_addr_in,
  output reg chip_sel_low_active,
  output reg chip_sel_high_active,
  output reg write_strobe_n,
  output reg output_strobe_n,
  output reg lower_byte_strobe_n,
  output reg upper_byte_strobe_n,
  input wire [DW-1:0] data_bus_io_in,
  output reg [DW-1:0] data_bus_io_out,
  output reg data_bus_io_oe_n
);
  // ==========================================
  // States and timing
  localparam [2:0] ST_POWERUP = 3'h0;
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_SETUP = 3'h2;
  localparam [2:0] ST_ACTIVE = 3'h3;
  localparam [2:0] ST_HOLD = 3'h4;
  localparam [2:0] ST_GAP = 3'h5;
  localparam [2:0] ST_DOWN = 3'h6;
  localparam TW = 8;
  localparam integer I_ACTIVE = `NPSP_CYC_ACTIVE;
  localparam integer I_CYCLE = `NPSP_CYC_CYCLE;
  localparam integer I_PRE = `NPSP_CYC_PRECHARGE;
  localparam integer I_HOLD = `NPSP_CYC_HOLD;
  localparam integer I_BSET = `NPSP_CYC_BYTE_SETUP;
  localparam integer I_POWER = `NPSP_CYC_POWER;
  localparam integer I_ACCESS = `NPSP_CYC_ACCESS;
  // Cycle counts cut to the timer width on purpose
  localparam [TW-1:0] C_ACTIVE = I_ACTIVE[TW-1:0];
  localparam [TW-1:0] C_CYCLE = I_CYCLE[TW-1:0];
  localparam [TW-1:0] C_PRE = I_PRE[TW-1:0];
  localparam [TW-1:0] C_HOLD = I_HOLD[TW-1:0];
  localparam [TW-1:0] C_BSET = I_BSET[TW-1:0];
  localparam [TW-1:0] C_POWER = I_POWER[TW-1:0];
  localparam [TW-1:0] C_ACCESS = I_ACCESS[TW-1:0];

  reg [2:0] state_q;
  reg write_q;
  reg [TW-1:0] cyc_cnt_q;
  reg [DW-1:0] rd_sync1_q;
  reg [DW-1:0] rd_sync2_q;
  reg timer_load;
  reg [TW-1:0] timer_value;
  wire timer_done;
  wire cycle_done;
  wire [1:0] lanes;

  // Lane mask: a request with no lane still uses both, so standby never hides it
  function [1:0] lane_mask;
    input [1:0] en;
    begin
      lane_mask = (en == 2'b00) ? 2'b11 : en;
    end
  endfunction
  assign lanes = lane_mask(req_byte_en);

  // ==========================================
  // Phase timer
  npsp_timer #(
    .W(TW)
  ) u_timer (
    .clk_sys(clk_sys),
    .reset(reset),
    .load(timer_load),
    .value(timer_value),
    .done(timer_done)
  );

  // Whole-cycle counter from strobe fall
  always @(posedge clk_sys) begin
    if (reset) begin
      cyc_cnt_q <= {TW{1'b0}};
    end else if (state_q == ST_ACTIVE && !timer_done && cyc_cnt_q == {TW{1'b0}}) begin
      cyc_cnt_q <= C_CYCLE; // RULE_08 RULE_10
    end else if (cyc_cnt_q != {TW{1'b0}}) begin
      cyc_cnt_q <= cyc_cnt_q - 8'h01;
    end
  end
  assign cycle_done = (cyc_cnt_q == {TW{1'b0}});

  // Read data synchroniser from the pins
  always @(posedge clk_sys) begin
    if (reset) begin
      rd_sync1_q <= {DW{1'b0}};
      rd_sync2_q <= {DW{1'b0}};
    end else begin
      rd_sync1_q <= data_bus_io_in;
      rd_sync2_q <= rd_sync1_q;
    end
  end

  // Timer loads on each phase entry
  always @* begin
    timer_load = 1'b0;
    timer_value = {TW{1'b0}};
    case (state_q)
      ST_POWERUP: begin
        timer_load = 1'b1;
        timer_value = C_POWER; // RULE_14
      end
      ST_IDLE: begin
        if (power_down_req && !req_valid) begin
          timer_load = 1'b1;
          timer_value = C_POWER; // RULE_13
        end else if (req_valid && req_ready) begin
          timer_load = 1'b1;
          timer_value = C_BSET; // RULE_12
        end
      end
      ST_SETUP: begin
        if (timer_done) begin
          timer_load = 1'b1;
          timer_value = write_q ? C_ACTIVE : ((C_ACTIVE > C_ACCESS + 8'h02) ? C_ACTIVE : C_ACCESS + 8'h02);
        end
      end
      ST_ACTIVE: begin
        if (timer_done) begin
          timer_load = 1'b1;
          timer_value = write_q ? C_HOLD : C_PRE; // RULE_11 RULE_09
        end
      end
      ST_HOLD: begin
        if (timer_done) begin
          timer_load = 1'b1;
          timer_value = C_PRE; // RULE_09
        end
      end
      default: begin
        timer_load = 1'b0;
      end
    endcase
  end

  // ==========================================
  // Sequencer, strobe-controlled cycles (output strobe for reads, write strobe for writes)
  always @(posedge clk_sys) begin
    if (reset) begin
      state_q <= ST_POWERUP;
      write_q <= 1'b0;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= {DW{1'b0}};
      power_safe <= 1'b0;
      word_addr_in <= {AW{1'b0}};
      chip_sel_low_active <= 1'b1; // RULE_14
      chip_sel_high_active <= 1'b0;
      write_strobe_n <= 1'b1;
      output_strobe_n <= 1'b1;
      lower_byte_strobe_n <= 1'b1;
      upper_byte_strobe_n <= 1'b1;
      data_bus_io_out <= {DW{1'b0}};
      data_bus_io_oe_n <= 1'b1;
    end else begin
      rsp_valid <= 1'b0;
      case (state_q)
        ST_POWERUP: begin
          // Timer holds the power-up time; the gap state keeps the select inactive until it runs out
          power_safe <= 1'b0;
          state_q <= ST_GAP; // RULE_14
        end
        ST_IDLE: begin
          if (power_down_req && !req_valid) begin
            req_ready <= 1'b0;
            chip_sel_low_active <= 1'b1; // RULE_13
            chip_sel_high_active <= 1'b0;
            state_q <= ST_DOWN;
          end else if (req_valid && req_ready) begin
            req_ready <= 1'b0;
            write_q <= req_write;
            word_addr_in <= req_addr; // RULE_01
            chip_sel_low_active <= 1'b0;
            chip_sel_high_active <= 1'b1;
            lower_byte_strobe_n <= ~lanes[0]; // RULE_03 RULE_12
            upper_byte_strobe_n <= ~lanes[1]; // RULE_03 RULE_12
            if (req_write) begin
              data_bus_io_out <= req_wdata; // RULE_11
              data_bus_io_oe_n <= 1'b0; // RULE_15
            end
            state_q <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          if (timer_done) begin
            // Strobe fall with address, data and lanes already stable
            if (write_q) begin
              write_strobe_n <= 1'b0; // RULE_07
            end else begin
              output_strobe_n <= 1'b0; // RULE_06
            end
            state_q <= ST_ACTIVE;
          end
        end
        ST_ACTIVE: begin
          if (timer_done) begin
            if (!write_q) begin
              rsp_rdata <= rd_sync2_q; // RULE_06
              rsp_valid <= 1'b1;
              output_strobe_n <= 1'b1;
              state_q <= ST_GAP;
            end else begin
              write_strobe_n <= 1'b1; // RULE_10
              state_q <= ST_HOLD;
            end
            lower_byte_strobe_n <= 1'b1;
            upper_byte_strobe_n <= 1'b1;
          end
        end
        ST_HOLD: begin
          // Data stays driven past the latching edge
          if (timer_done) begin
            data_bus_io_oe_n <= 1'b1; // RULE_11
            state_q <= ST_GAP;
          end
        end
        ST_GAP: begin
          // Precharge and full cycle time before the next start
          if (timer_done && cycle_done) begin
            chip_sel_low_active <= 1'b0; // RULE_09
            chip_sel_high_active <= 1'b1;
            req_ready <= 1'b1;
            state_q <= ST_IDLE;
          end else begin
            chip_sel_low_active <= 1'b1; // RULE_02
            chip_sel_high_active <= 1'b0;
          end
        end
        ST_DOWN: begin
          // Hold select inactive, then report safe to cut power
          if (timer_done && cycle_done) begin
            power_safe <= 1'b1; // RULE_13
          end
          if (!power_down_req) begin
            power_safe <= 1'b0;
            state_q <= ST_POWERUP;
          end
        end
        default: begin
          state_q <= ST_POWERUP;
        end
      endcase
    end
  end
endmodule // npsp_host

// ===== test/npsp_host_assertions.sv
`timescale 1ns/10ps
// ====
// Pin timing checker
module npsp_host_assertions (
  // Clock and reset
  input wire clk_sys,
  input wire reset,
  // Memory pins
  input wire chip_sel_low_active,
  input wire chip_sel_high_active,
  input wire write_strobe_n,
  input wire output_strobe_n,
  input wire lower_byte_strobe_n,
  input wire upper_byte_strobe_n,
  input wire [15:0] data_bus_io_out,
  input wire data_bus_io_oe_n
);
  reg [7:0] lo_q = 8'h00;
  reg [7:0] hi_q = 8'hFF;
  reg [7:0] per_q = 8'hFF;
  wire idle = output_strobe_n && write_strobe_n;
  wire sel = !chip_sel_low_active && chip_sel_high_active;
  wire [1:0] lane = {upper_byte_strobe_n, lower_byte_strobe_n};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Strobe low span, idle span, cycles since the last strobe fall
  always @(posedge clk_sys) begin
    if (reset) begin
      lo_q <= 8'h00;
      hi_q <= 8'hFF;
      per_q <= 8'hFF;
    end else begin
      lo_q <= idle ? 8'h00 : lo_q + 8'h01;
      hi_q <= idle ? hi_q + {7'h00, hi_q != 8'hFF} : 8'h00;
      per_q <= ($fell(output_strobe_n) || $fell(write_strobe_n)) ? 8'h01 : per_q + {7'h00, per_q != 8'hFF};
    end
  end
  sequence hold_seq;
    (!data_bus_io_oe_n && $stable(data_bus_io_out))[*8] ##1 (!data_bus_io_oe_n && $stable(data_bus_io_out))[*6];
  endsequence
  sequence parked_seq;
    chip_sel_low_active[*8] ##1 chip_sel_low_active[*8] ##1 chip_sel_low_active[*6];
  endsequence
  a_read_width: assert property ($rose(output_strobe_n) |-> lo_q >= 8'h1E)
    else $error("read strobe short");
  a_write_width: assert property ($rose(write_strobe_n) |-> lo_q >= 8'h1E)
    else $error("write strobe short");
  a_strobe_precharge: assert property ($fell(output_strobe_n) || $fell(write_strobe_n) |-> hi_q >= 8'h05)
    else $error("precharge short");
  a_cycle_period: assert property ($fell(output_strobe_n) || $fell(write_strobe_n) |-> per_q >= 8'h26)
    else $error("cycle short");
  a_data_hold: assert property ($fell(write_strobe_n) |-> hold_seq)
    else $error("write data not held");
  a_lane_setup: assert property ($fell(output_strobe_n) || $fell(write_strobe_n) |->
    lane != 2'h3 && $past(lane, 2) == lane) else $error("byte strobes late");
  a_write_qualify: assert property ($fell(write_strobe_n) |-> sel && output_strobe_n && !data_bus_io_oe_n)
    else $error("write strobe unqualified");
  a_read_qualify: assert property ($fell(output_strobe_n) |-> sel && write_strobe_n && data_bus_io_oe_n)
    else $error("read strobe unqualified");
  a_powerup_park: assert property ($fell(reset) |-> parked_seq)
    else $error("select left idle early");
endmodule // npsp_host_assertions

// ===== test/npsp_mem_model.sv
`timescale 1ns/10ps
// ====
// Behavioural memory behind the host port
module npsp_mem_model #(
  parameter ACC_NS = 100
) (
  // Pins from the host
  input wire [15:0] word_addr_in,
  input wire chip_sel_low_active,
  input wire chip_sel_high_active,
  input wire write_strobe_n,
  input wire output_strobe_n,
  input wire lower_byte_strobe_n,
  input wire upper_byte_strobe_n,
  input wire [15:0] data_bus_io_out,
  input wire data_bus_io_oe_n,
  // Resolved data bus
  output wire [15:0] data_bus_io_in
);
  reg [15:0] mem_q [0:65535];
  reg [15:0] dout_q = 16'h0000;
  reg [15:0] last_q = 16'h0000;
  reg rd_q = 1'b0;
  wire sel = !chip_sel_low_active && chip_sel_high_active;
  wire [1:0] lane = ~{upper_byte_strobe_n, lower_byte_strobe_n};
  wire rd_on = rd_q && sel && write_strobe_n;
  wire [15:0] drv = {{8{rd_on && lane[1]}}, {8{rd_on && lane[0]}}};
  // Host data wins; floating lanes show the inverse of the last value
  assign data_bus_io_in = !data_bus_io_oe_n ? data_bus_io_out : (drv & dout_q) | (~drv & ~last_q);
  // Read: address taken at strobe fall, lanes driven after the access time
  always @(negedge output_strobe_n) begin
    if (sel && write_strobe_n) begin
      dout_q = mem_q[word_addr_in];
      #(ACC_NS) rd_q = !output_strobe_n;
    end
  end
  // Strobe rise floats the lanes
  always @(posedge output_strobe_n) begin
    rd_q = 1'b0;
    last_q = dout_q;
  end
  // Select-controlled cycles: the select edge latches address and data
  always @(negedge chip_sel_low_active or posedge chip_sel_high_active) begin
    if (sel && !write_strobe_n && output_strobe_n) begin
      if (lane[0]) mem_q[word_addr_in][7:0] = data_bus_io_in[7:0];
      if (lane[1]) mem_q[word_addr_in][15:8] = data_bus_io_in[15:8];
      last_q = data_bus_io_in;
    end else if (sel && !output_strobe_n && write_strobe_n) begin
      dout_q = mem_q[word_addr_in];
      #(ACC_NS) rd_q = !output_strobe_n;
    end
  end
  // Write: selected lanes stored at strobe fall
  always @(negedge write_strobe_n) begin
    if (sel && output_strobe_n) begin
      if (lane[0]) mem_q[word_addr_in][7:0] = data_bus_io_in[7:0];
      if (lane[1]) mem_q[word_addr_in][15:8] = data_bus_io_in[15:8];
      last_q = data_bus_io_in;
    end
  end
endmodule // npsp_mem_model

// ===== test/npsp_host_tb.sv
`timescale 1ns/10ps
`include "npsp_defs.vh"
// ====
// Bench for the host port
module npsp_host_tb;
  reg clk_sys = 1'b0;
  reg reset = 1'b1;
  reg req_valid = 1'b0;
  reg req_write = 1'b0;
  reg power_down_req = 1'b0;
  reg [15:0] req_addr = 16'h0000;
  reg [15:0] req_wdata = 16'h0000;
  reg [1:0] req_byte_en = 2'h3;
  reg [15:0] q;
  integer fails = 0;
  integer check_count = 0;
  wire [15:0] rsp_rdata, word_addr_in, data_bus_io_in, data_bus_io_out;
  wire req_ready, rsp_valid, power_safe, chip_sel_low_active, chip_sel_high_active, data_bus_io_oe_n;
  wire write_strobe_n, output_strobe_n, lower_byte_strobe_n, upper_byte_strobe_n;
  npsp_host dut (
    .clk_sys(clk_sys),
    .reset(reset),
    .req_valid(req_valid),
    .req_write(req_write),
    .req_addr(req_addr),
    .req_wdata(req_wdata),
    .req_byte_en(req_byte_en),
    .req_ready(req_ready),
    .rsp_rdata(rsp_rdata),
    .rsp_valid(rsp_valid),
    .power_down_req(power_down_req),
    .power_safe(power_safe),
    .word_addr_in(word_addr_in),
    .chip_sel_low_active(chip_sel_low_active),
    .chip_sel_high_active(chip_sel_high_active),
    .write_strobe_n(write_strobe_n),
    .output_strobe_n(output_strobe_n),
    .lower_byte_strobe_n(lower_byte_strobe_n),
    .upper_byte_strobe_n(upper_byte_strobe_n),
    .data_bus_io_in(data_bus_io_in),
    .data_bus_io_out(data_bus_io_out),
    .data_bus_io_oe_n(data_bus_io_oe_n)
  );
  npsp_mem_model mem (
    .word_addr_in(word_addr_in),
    .chip_sel_low_active(chip_sel_low_active),
    .chip_sel_high_active(chip_sel_high_active),
    .write_strobe_n(write_strobe_n),
    .output_strobe_n(output_strobe_n),
    .lower_byte_strobe_n(lower_byte_strobe_n),
    .upper_byte_strobe_n(upper_byte_strobe_n),
    .data_bus_io_out(data_bus_io_out),
    .data_bus_io_oe_n(data_bus_io_oe_n),
    .data_bus_io_in(data_bus_io_in)
  );
  // Free-running clock
  initial forever #2 clk_sys = ~clk_sys;
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task test_done;
    begin
      $display("checks=%0d mismatches=%0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  // Bounded wait at falling edges: 0 ready, 1 read answer, 2 power safe
  task wait_flag(input integer which);
    integer n;
    begin
      n = 0;
      while (n < 200 && ((which == 0) ? req_ready : (which == 1) ? rsp_valid : power_safe) !== 1'b1) begin
        @(negedge clk_sys);
        n = n + 1;
      end
      if (n == 200) begin
        fails = fails + 1;
        test_done;
      end
    end
  endtask
  // One request; read data lands in q
  task xfer(input w, input [15:0] a, input [15:0] d, input [1:0] be);
    begin
      wait_flag(0);
      req_valid = 1'b1;
      req_write = w;
      req_addr = a;
      req_wdata = d;
      req_byte_en = be;
      @(negedge clk_sys);
      req_valid = 1'b0;
      if (!w) wait_flag(1);
      q = rsp_rdata;
    end
  endtask
  // Back-to-back writes at both ends of the array, then read back
  task t_ends;
    begin
      xfer(1'b1, 16'h0000, 16'hA5C3, 2'h3);
      xfer(1'b1, 16'hFFFF, 16'h5A3C, 2'h3);
      xfer(1'b0, 16'h0000, 16'h0000, 2'h3);
      chk(q, 16'hA5C3);
      xfer(1'b0, 16'hFFFF, 16'h0000, 2'h3);
      chk(q, 16'h5A3C);
    end
  endtask
  // Single-lane writes merge; an empty lane mask writes both lanes
  task t_lanes;
    begin
      xfer(1'b1, 16'h1234, 16'h1111, 2'h3);
      xfer(1'b1, 16'h1234, 16'h22AA, 2'h1);
      xfer(1'b1, 16'h1234, 16'h77EE, 2'h2);
      xfer(1'b0, 16'h1234, 16'h0000, 2'h1);
      chk({8'h00, q[7:0]}, 16'h00AA);
      xfer(1'b0, 16'h1234, 16'h0000, 2'h3);
      chk(q, 16'h77AA);
      xfer(1'b1, 16'h0040, 16'hBEEF, 2'h0);
      xfer(1'b0, 16'h0040, 16'h0000, 2'h0);
      chk(q, 16'hBEEF);
    end
  endtask
  // Power-down parks the low-active select the power time before power is safe; data survives
  task t_power;
    integer n;
    reg parked;
    begin
      wait_flag(0);
      power_down_req = 1'b1;
      n = 0;
      parked = 1'b1;
      while (n < 100 && power_safe !== 1'b1) begin
        @(negedge clk_sys);
        n = n + 1;
        if (chip_sel_low_active !== 1'b1) parked = 1'b0;
      end
      wait_flag(2);
      chk({15'h0000, parked}, 16'h0001);
      chk({15'h0000, n >= `NPSP_CYC_POWER}, 16'h0001);
      chk({15'h0000, chip_sel_low_active}, 16'h0001);
      power_down_req = 1'b0;
      xfer(1'b0, 16'hFFFF, 16'h0000, 2'h3);
      chk(q, 16'h5A3C);
      chk({15'h0000, power_safe}, 16'h0000);
    end
  endtask
  // Reset for 20 cycles, then the scenarios
  initial begin
    repeat (20) @(negedge clk_sys);
    reset = 1'b0;
    t_ends;
    t_lanes;
    t_power;
    test_done;
  end
endmodule // npsp_host_tb
bind npsp_host npsp_host_assertions chk_i (
  .clk_sys(clk_sys),
  .reset(reset),
  .chip_sel_low_active(chip_sel_low_active),
  .chip_sel_high_active(chip_sel_high_active),
  .write_strobe_n(write_strobe_n),
  .output_strobe_n(output_strobe_n),
  .lower_byte_strobe_n(lower_byte_strobe_n),
  .upper_byte_strobe_n(upper_byte_strobe_n),
  .data_bus_io_out(data_bus_io_out),
  .data_bus_io_oe_n(data_bus_io_oe_n)
);
